// ### twdt_pkg.sv
// Overview of operation
// - start strobe hands data pin to link
// - stop rising edge returns pin to user
// - every field shifts least significant bit first
// - two-bit code: 00 data read, 10 address read
// - code 01 data write, 11 address write
// - length code plus one gives byte count
// - address field as wide as selector
// - any reset clears selector to part identifier
// - wait field: zeros until done, then one
// - selector picks data register for data frames
// - address read returns busy, error, status byte
// - input pending set by write to programming port, cleared by ack
// - output available follows engine output flag
// - data register 0x00 is read-only part identifier
// - data register 0x01 is read-only revision identifier
// - instruction fixes who drives data line
// - one shift register serves all transfers
// - low pulse length tells reset from strobe
// - low of 20 us is reset, strobes shorter
// - data sampled on link clock rising edge
// - short registers read right-justified, zero padded
package twdt_pkg;

  // timing of the shared clock and reset pin
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RST_LOW_NS = 20000;
  localparam int unsigned RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_MAX_NS = 5000;
  localparam int unsigned STROBE_MAX_CYC = STROBE_MAX_NS / CLK_PERIOD_NS;

  // field widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned SH_W = 32;
  localparam int unsigned CNT_W = 5;

  // instruction codes
  localparam logic [1:0] INS_DATA_RD = 2'h0;
  localparam logic [1:0] INS_DATA_WR = 2'h1;
  localparam logic [1:0] INS_ADDR_RD = 2'h2;
  localparam logic [1:0] INS_ADDR_WR = 2'h3;

  // selector values and bit counts
  localparam logic [SEL_W-1:0] SEL_PART_ID = 8'h00;
  localparam logic [SEL_W-1:0] SEL_REV_ID = 8'h01;
  localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] ADDR_LAST = 5'h07;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // wait field bit values
  localparam logic WAIT_BUSY = 1'b0;
  localparam logic WAIT_DONE = 1'b1;

  // status byte returned by an address read
  typedef struct packed {
    logic mem_busy;
    logic mem_err;
    logic [3:0] unused;
    logic in_pend;
    logic out_avail;
  } twdt_status_t;

  // request word passed from the link to the system side
  typedef struct packed {
    logic [1:0] instruction_field;
    logic [BYTE_W-1:0] data;
  } twdt_req_t;

  // frame states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_INS = 4'h1,
    S_LEN = 4'h3,
    S_DATA_W = 4'h2,
    S_WAIT = 4'h6,
    S_DATA_R = 4'h7,
    S_STOP = 4'h5,
    S_ADDR_W = 4'h4,
    S_ADDR_R = 4'hc
  } twdt_state_t;

endpackage : twdt_pkg

// ### twdt_target.sv
`timescale 1ns/100ps
module twdt_target
  import twdt_pkg::*;
#(
  parameter logic [BYTE_W-1:0] PART_ID = 8'h5a, // arbitrary value
  parameter logic [BYTE_W-1:0] REV_ID = 8'h3c, // arbitrary value
  parameter logic [SEL_W-1:0] PROG_SEL = 8'h02,
  parameter int unsigned RST_CYC = RST_LOW_CYC
)(
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // shared clock and reset pin, clocks the link logic
  input wire logic link_clock_pin,
  // link data pin
  input wire logic link_data_pin_val,
  output logic link_data_pin_drv,
  output logic link_data_pin_en,
  // user function sharing the data pin
  input wire logic user_drive,
  input wire logic user_drive_en,
  output logic user_sense,
  // device reset from a long low on the shared pin
  output logic dev_reset,
  // programming engine status
  input wire logic eng_mem_busy,
  input wire logic eng_mem_err,
  input wire logic eng_out_ready,
  input wire logic eng_in_ack,
  // data register port
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  output logic [SEL_W-1:0] reg_addr,
  output logic [BYTE_W-1:0] reg_wdata,
  input wire logic [BYTE_W-1:0] reg_rdata,
  input wire logic reg_done
);

  localparam int unsigned LOW_W = $clog2(RST_CYC + 1);
  localparam logic [LOW_W-1:0] LOW_MAX = LOW_W'(RST_CYC);
  localparam logic [LOW_W-1:0] LOW_FIRE = LOW_W'(RST_CYC - 1);

  // refuse counts that cannot tell a reset from a strobe
  if (RST_CYC <= STROBE_MAX_CYC)
  begin : g_bad_rst_cyc
    $error("reset low count must exceed the strobe low limit");
  end
  if (PROG_SEL == SEL_PART_ID || PROG_SEL == SEL_REV_ID)
  begin : g_bad_prog_sel
    $error("programming data port must not alias an identifier");
  end

  // ---------------- system clock domain ----------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic [LOW_W-1:0] low_cnt_r;
  logic dev_reset_r;
  logic rst_tgl_r;
  logic fire_w;
  logic rq_s1_r;
  logic rq_s2_r;
  logic rq_s3_r;
  logic req_evt;
  logic [SEL_W-1:0] sel_r;
  logic sel_local;
  logic acc_busy_r;
  logic acc_rd_r;
  logic ack_tgl_r;
  logic wr_stb_r;
  logic rd_stb_r;
  logic [BYTE_W-1:0] wdata_r;
  logic [BYTE_W-1:0] rd_data_r;
  logic in_pend_r;
  logic in_set;
  twdt_status_t status_r;

  // ---------------- link clock domain ----------------
  logic lsr_s1_r;
  logic lsr_s2_r;
  logic rt_s1_r;
  logic rt_s2_r;
  logic rt_seen_r;
  logic rst_evt;
  logic ak_s1_r;
  logic ak_s2_r;
  logic pend;
  twdt_status_t st_s1_r;
  twdt_status_t st_s2_r;
  twdt_state_t fsm_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last_idx;
  logic [1:0] ins_r;
  logic [1:0] ins_nxt;
  logic [1:0] len_r;
  logic [SH_W-1:0] sh_r;
  logic sh_lsb;
  logic dout_r;
  logic doe_r;
  logic req_tgl_r;
  twdt_req_t req_r;
  logic aw_want_r;
  logic [SEL_W-1:0] aw_data_r;
  logic dq_want_r;
  logic aw_set;
  logic dq_set;
  logic wait_done;
  logic act;

  // shared pin level brought into the system domain
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= link_clock_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign fire_w = !pin_s2_r && (low_cnt_r == LOW_FIRE);

  always_ff @(posedge clk)
  begin
    if (sys_rst || pin_s2_r)
    begin
      low_cnt_r <= '0;
      dev_reset_r <= 1'b0;
    end
    else if (low_cnt_r != LOW_MAX)
    begin
      low_cnt_r <= low_cnt_r + 1'b1;
      dev_reset_r <= fire_w;
    end
  end

  // reset event toggled over to the link domain
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rst_tgl_r <= 1'b0;
    else if (fire_w)
      rst_tgl_r <= ~rst_tgl_r;
  end

  // request toggle synchroniser and edge detect
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_s3_r <= 1'b0;
    end
    else
    begin
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      rq_s3_r <= rq_s2_r;
    end
  end
  assign req_evt = rq_s2_r ^ rq_s3_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst || fire_w)
      sel_r <= SEL_RESET;
    else if (req_evt && req_r.instruction_field == INS_ADDR_WR)
      sel_r <= req_r.data;
  end

  assign sel_local = (sel_r == SEL_PART_ID) || (sel_r == SEL_REV_ID);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_busy_r <= 1'b0;
      acc_rd_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      wdata_r <= '0;
      rd_data_r <= '0;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      if (acc_busy_r)
      begin
        if (reg_done)
        begin
          acc_busy_r <= 1'b0;
          ack_tgl_r <= ~ack_tgl_r;
          if (acc_rd_r)
            rd_data_r <= reg_rdata;
        end
      end
      else if (req_evt)
      begin
        case (req_r.instruction_field)
          INS_DATA_WR:
          begin
            // identifier registers ignore writes
            if (sel_local)
              ack_tgl_r <= ~ack_tgl_r;
            else
            begin
              wr_stb_r <= 1'b1;
              wdata_r <= req_r.data;
              acc_busy_r <= 1'b1;
              acc_rd_r <= 1'b0;
            end
          end
          INS_DATA_RD:
          begin
            if (sel_r == SEL_PART_ID)
            begin
              rd_data_r <= PART_ID;
              ack_tgl_r <= ~ack_tgl_r;
            end
            else if (sel_r == SEL_REV_ID)
            begin
              rd_data_r <= REV_ID;
              ack_tgl_r <= ~ack_tgl_r;
            end
            else
            begin
              rd_stb_r <= 1'b1;
              acc_busy_r <= 1'b1;
              acc_rd_r <= 1'b1;
            end
          end
          default: ack_tgl_r <= ~ack_tgl_r;
        endcase
      end
    end
  end

  assign in_set = req_evt && !acc_busy_r && (req_r.instruction_field == INS_DATA_WR) && (sel_r == PROG_SEL);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      in_pend_r <= 1'b0;
    else
      in_pend_r <= in_set || (in_pend_r && !eng_in_ack);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      status_r <= '0;
    else
      status_r <= '{mem_busy: eng_mem_busy, mem_err: eng_mem_err, unused: 4'h0,
                    in_pend: in_pend_r, out_avail: eng_out_ready};
  end

  assign dev_reset = dev_reset_r;
  assign reg_wr_stb = wr_stb_r;
  assign reg_rd_stb = rd_stb_r;
  assign reg_addr = sel_r;
  assign reg_wdata = wdata_r;

  // link side synchronisers: system reset, reset event, acknowledge, status
  always_ff @(posedge link_clock_pin)
  begin
    lsr_s1_r <= sys_rst;
    lsr_s2_r <= lsr_s1_r;
    rt_s1_r <= rst_tgl_r;
    rt_s2_r <= rt_s1_r;
    ak_s1_r <= ack_tgl_r;
    ak_s2_r <= ak_s1_r;
    st_s1_r <= status_r;
    st_s2_r <= st_s1_r;
  end

  always_ff @(posedge link_clock_pin)
  begin
    if (lsr_s2_r)
      rt_seen_r <= 1'b0;
    else
      rt_seen_r <= rt_s2_r;
  end

  assign rst_evt = rt_s2_r ^ rt_seen_r;
  assign pend = req_tgl_r ^ ak_s2_r;
  assign ins_nxt = {link_data_pin_val, ins_r[1]};
  assign sh_lsb = sh_r[0];
  // data field last bit index from length
  assign last_idx = {len_r, BYTE_LAST};
  assign aw_set = (fsm_r == S_ADDR_W) && (cnt_r == ADDR_LAST);
  assign dq_set = ((fsm_r == S_LEN) && (cnt_r != '0) && (ins_r == INS_DATA_RD))
                  || ((fsm_r == S_DATA_W) && (cnt_r == last_idx));
  assign wait_done = !pend && !aw_want_r && !dq_want_r;

  // requests to the system side, address writes first
  always_ff @(posedge link_clock_pin)
  begin
    if (lsr_s2_r)
    begin
      req_tgl_r <= 1'b0;
      req_r <= '0;
      aw_want_r <= 1'b0;
      aw_data_r <= '0;
      dq_want_r <= 1'b0;
    end
    else if (rst_evt)
    begin
      aw_want_r <= 1'b0;
      dq_want_r <= 1'b0;
    end
    else
    begin
      if (aw_set)
      begin
        aw_want_r <= 1'b1;
        aw_data_r <= {link_data_pin_val, sh_r[SH_W-1 -: SEL_W-1]};
      end
      else if (!pend && aw_want_r)
      begin
        req_r <= '{instruction_field: INS_ADDR_WR, data: aw_data_r};
        req_tgl_r <= ~req_tgl_r;
        aw_want_r <= 1'b0;
      end
      if (dq_set)
        dq_want_r <= 1'b1;
      else if (!pend && !aw_want_r && dq_want_r)
      begin
        req_r <= '{instruction_field: ins_r, data: sh_r[SH_W-1 -: BYTE_W]};
        req_tgl_r <= ~req_tgl_r;
        dq_want_r <= 1'b0;
      end
    end
  end

  // frame sequencer, one bit time per rising edge
  // data sampled on rising edge
  always_ff @(posedge link_clock_pin)
  begin
    if (lsr_s2_r)
    begin
      fsm_r <= S_IDLE;
      cnt_r <= '0;
      ins_r <= '0;
      len_r <= '0;
      sh_r <= '0;
      dout_r <= 1'b0;
      doe_r <= 1'b0;
    end
    // reset drops the frame; edge is first code bit
    else if (rst_evt)
    begin
      fsm_r <= S_INS;
      cnt_r <= CNT_W'(1);
      ins_r <= {link_data_pin_val, 1'b0};
      doe_r <= 1'b0;
    end
    else
    begin
      unique case (fsm_r)
        S_IDLE:
        begin
          fsm_r <= S_INS;
          cnt_r <= '0;
          doe_r <= 1'b0;
        end
        S_INS:
        begin
          ins_r <= ins_nxt;
          cnt_r <= (cnt_r == '0) ? CNT_W'(1) : '0;
          if (cnt_r != '0)
          begin
            if (ins_nxt == INS_ADDR_WR)
              fsm_r <= S_ADDR_W;
            else if (ins_nxt == INS_ADDR_RD)
            begin
              sh_r <= SH_W'(st_s2_r);
              fsm_r <= S_ADDR_R;
            end
            else
              fsm_r <= S_LEN;
          end
        end
        S_LEN:
        begin
          len_r <= {link_data_pin_val, len_r[1]};
          cnt_r <= (cnt_r == '0) ? CNT_W'(1) : '0;
          if (cnt_r != '0)
            fsm_r <= (ins_r == INS_DATA_WR) ? S_DATA_W : S_WAIT;
        end
        S_ADDR_W,
        S_DATA_W:
        begin
          sh_r <= {link_data_pin_val, sh_r[SH_W-1:1]};
          cnt_r <= cnt_r + 1'b1;
          if (fsm_r == S_ADDR_W && cnt_r == ADDR_LAST)
            fsm_r <= S_STOP;
          else if (fsm_r == S_DATA_W && cnt_r == last_idx)
          begin
            fsm_r <= S_WAIT;
            cnt_r <= '0;
          end
        end
        // zeros until access done, then one
        S_WAIT:
        begin
          doe_r <= 1'b1;
          if (wait_done)
          begin
            dout_r <= WAIT_DONE;
            if (ins_r == INS_DATA_RD)
            begin
              sh_r <= SH_W'(rd_data_r);
              fsm_r <= S_DATA_R;
            end
            else
              fsm_r <= S_STOP;
          end
          else
            dout_r <= WAIT_BUSY;
        end
        // device drives only its own fields
        S_ADDR_R,
        S_DATA_R:
        begin
          doe_r <= 1'b1;
          dout_r <= sh_r[0];
          sh_r <= {1'b0, sh_r[SH_W-1:1]};
          cnt_r <= cnt_r + 1'b1;
          if ((fsm_r == S_ADDR_R && cnt_r == ADDR_LAST) || (fsm_r == S_DATA_R && cnt_r == last_idx))
          begin
            fsm_r <= S_STOP;
            cnt_r <= '0;
          end
        end
        S_STOP:
        begin
          fsm_r <= S_IDLE;
          cnt_r <= '0;
          doe_r <= 1'b0;
        end
        default:
        begin
          fsm_r <= S_IDLE;
          doe_r <= 1'b0;
        end
      endcase
    end
  end

  // pin sharing between link and user function
  assign act = (fsm_r != S_IDLE);
  assign link_data_pin_drv = act ? dout_r : user_drive;
  assign link_data_pin_en = act ? doe_r : user_drive_en;
  assign user_sense = link_data_pin_val;

  // checks in the system domain
  AST_SEL_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    fire_w |=> sel_r == SEL_RESET) else $error("selector not cleared by reset");
  AST_RESET_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(dev_reset) |-> $past(low_cnt_r) == LOW_FIRE && low_cnt_r == LOW_MAX)
    else $error("device reset without full low time");
  AST_RESET_END: assert property (@(posedge clk) disable iff (sys_rst)
    pin_s2_r |=> !dev_reset) else $error("device reset held with pin high");
  AST_INPEND_SET: assert property (@(posedge clk) disable iff (sys_rst)
    in_set |=> in_pend_r ##1 status_r.in_pend) else $error("input pending not set after port write");
  AST_INPEND_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    in_pend_r && eng_in_ack && !in_set |=> !in_pend_r) else $error("input pending not cleared by ack");
  AST_OUT_AVAIL: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> status_r.out_avail == $past(eng_out_ready)) else $error("output available mismatch");
  AST_WRITE_STEER: assert property (@(posedge clk) disable iff (sys_rst)
    req_evt && !acc_busy_r && req_r.instruction_field == INS_DATA_WR && !sel_local |=> reg_wr_stb && reg_addr == $past(sel_r))
    else $error("data write not steered by selector");

  // checks in the link domain
  AST_START_CLAIM: assert property (@(posedge link_clock_pin) disable iff (lsr_s2_r)
    fsm_r == S_IDLE && !rst_evt |=> act && !link_data_pin_en) else $error("start did not claim pin");
  AST_STOP_RELEASE: assert property (@(posedge link_clock_pin) disable iff (lsr_s2_r)
    fsm_r == S_STOP && !rst_evt |=> !act && !doe_r) else $error("stop did not release pin");
  AST_MASTER_FIELDS: assert property (@(posedge link_clock_pin) disable iff (lsr_s2_r)
    fsm_r inside {S_INS, S_LEN, S_ADDR_W, S_DATA_W} |-> !doe_r) else $error("device drove a master field");
  AST_WAIT_END: assert property (@(posedge link_clock_pin) disable iff (lsr_s2_r)
    fsm_r == S_WAIT && !rst_evt |=> doe_r && dout_r == ($past(wait_done) ? WAIT_DONE : WAIT_BUSY))
    else $error("wait field bit wrong");
  AST_ADDR_READ_LEN: assert property (@(posedge link_clock_pin) disable iff (lsr_s2_r || rst_evt)
    fsm_r == S_INS && cnt_r != '0 && ins_nxt == INS_ADDR_RD |=> fsm_r == S_ADDR_R [*8] ##1 fsm_r == S_STOP)
    else $error("address read field length wrong");
  AST_LSB_FIRST: assert property (@(posedge link_clock_pin) disable iff (lsr_s2_r || rst_evt)
    fsm_r inside {S_ADDR_R, S_DATA_R} |=> dout_r == $past(sh_lsb)) else $error("bit order wrong");

endmodule : twdt_target

// ### twdt_master.sv
`timescale 1ns/100ps
module twdt_master
  import twdt_pkg::*;
(
  // shared clock and reset pin, driven by the programmer
  output logic link_clock_pin,
  // resolved data line and programmer driver
  output logic pin_val,
  output logic m_en,
  // device side of the data pin
  input wire logic dev_en,
  input wire logic dev_drv,
  // reference clock for the floating line pattern
  input wire logic clk
);
  logic m_val = 1'b0;
  logic float_v = 1'b0;

  // idle link clock stands high, driver off
  initial
  begin
    link_clock_pin = 1'b1;
    m_en = 1'b0;
  end

  // a released line wanders instead of keeping its last value
  always @(posedge clk) float_v <= ~float_v;
  assign pin_val = dev_en ? dev_drv : (m_en ? m_val : float_v);

  // one bit time, device bit read late in the high phase
  task automatic tick(input logic en, input logic v, output logic b);
    m_en = en;
    m_val = v;
    #2 link_clock_pin = 1'b0;
    // low phase far below the strobe limit
    #16 link_clock_pin = 1'b1;
    #14 b = pin_val;
  endtask : tick

  // whole frame, every field lsb first
  task automatic frame(input logic [1:0] instruction_field, input logic [1:0] len, input logic [31:0] wd,
                       output logic [31:0] rd, output bit ok);
    int n;
    logic b;
    // address field eight bits, data bytes from length
    n = instruction_field[1] ? 8 : 8 * (len + 1);
    rd = '0;
    ok = 1'b1;
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < 2; i++) tick(1'b1, instruction_field[i], b);
    if (!instruction_field[1]) for (int i = 0; i < 2; i++) tick(1'b1, len[i], b);
    if (instruction_field == INS_ADDR_WR || instruction_field == INS_DATA_WR) for (int i = 0; i < n; i++) tick(1'b1, wd[i], b);
    if (!instruction_field[1])
    begin
      ok = 1'b0;
      for (int i = 0; i < 300 && !ok; i++)
      begin
        tick(1'b0, 1'b0, b);
        ok = (b === 1'b1);
      end
    end
    if (instruction_field == INS_ADDR_RD || instruction_field == INS_DATA_RD)
      for (int i = 0; i < n; i++)
      begin
        tick(1'b0, 1'b0, b);
        rd[i] = b;
      end
    tick(1'b0, 1'b0, b);
  endtask : frame

  // long low on the shared pin resets the device
  task automatic pin_reset(input int lo_ns);
    m_en = 1'b0;
    link_clock_pin = 1'b0;
    #(lo_ns) link_clock_pin = 1'b1;
    #2000;
  endtask : pin_reset
endmodule : twdt_master

// ### twdt_target_tb.sv
`timescale 1ns/100ps
module twdt_target_tb;
  import twdt_pkg::*;
  localparam int unsigned RST_N = 120;
  localparam logic [7:0] PART = 8'h5a; // arbitrary value
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  localparam logic [7:0] PSEL = 8'h02;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic user_drive = 1'b0;
  logic user_drive_en = 1'b1;
  logic eng_mem_busy = 1'b0;
  logic eng_mem_err = 1'b0;
  logic eng_out_ready = 1'b0;
  logic eng_in_ack = 1'b0;
  logic reg_done = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic [1:0] busy_c = 2'h0;
  logic link_clock_pin, pin_val, m_en, dev_en, dev_drv, dev_reset, user_sense, reg_wr_stb, reg_rd_stb, b;
  logic [7:0] reg_addr, reg_wdata, wr_addr, wr_data;
  logic [31:0] rd;
  int err_count, comparisons, wr_cnt;

  // system clock
  initial forever #25 clk = ~clk;

  twdt_target #(.PART_ID(PART), .REV_ID(REV), .PROG_SEL(PSEL), .RST_CYC(RST_N)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .link_clock_pin(link_clock_pin), .link_data_pin_val(pin_val),
    .link_data_pin_drv(dev_drv), .link_data_pin_en(dev_en), .user_drive(user_drive),
    .user_drive_en(user_drive_en), .user_sense(user_sense), .dev_reset(dev_reset),
    .eng_mem_busy(eng_mem_busy), .eng_mem_err(eng_mem_err), .eng_out_ready(eng_out_ready),
    .eng_in_ack(eng_in_ack), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_done(reg_done));

  twdt_master i_m (.link_clock_pin(link_clock_pin), .pin_val(pin_val), .m_en(m_en), .dev_en(dev_en),
    .dev_drv(dev_drv), .clk(clk));

  // slow register behind the port, answers three clocks late
  always @(posedge clk)
  begin
    reg_done <= 1'b0;
    reg_rdata <= ~reg_rdata;
    if (reg_rd_stb || reg_wr_stb)
    begin
      busy_c <= 2'h3;
      if (reg_wr_stb)
      begin
        wr_addr <= reg_addr;
        wr_data <= reg_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
    else if (busy_c != 2'h0)
    begin
      busy_c <= busy_c - 2'h1;
      if (busy_c == 2'h1)
      begin
        reg_done <= 1'b1;
        reg_rdata <= reg_addr ^ 8'ha5;
      end
    end
  end

  // device must be off the line whenever the programmer drives it
  always @(negedge link_clock_pin) if (m_en === 1'b1) chk(dev_en, 1'b0, "both drive data line");

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s, seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  // one frame, then the pin must be back with the user function
  task automatic fr(input logic [1:0] instruction_field, input logic [1:0] len, input logic [31:0] wd);
    bit ok;
    wait_clk(1);
    user_drive = ~user_drive;
    i_m.frame(instruction_field, len, wd, rd, ok);
    chk(ok, 1'b1, "wait field never ended");
    chk(user_sense, pin_val, "user sense not following pin");
    chk({dev_en, dev_drv}, {1'b1, user_drive}, "pin not returned to user");
    chk(dev_reset, 1'b0, "strobe taken as reset");
  endtask : fr

  task automatic t_ident();
    int n;
    n = wr_cnt;
    fr(INS_DATA_RD, 2'h0, 32'h0);
    chk(rd, {24'h0, PART}, "part id after reset");
    fr(INS_DATA_WR, 2'h0, 32'h0000_0077);
    chk(wr_cnt, n, "part id write reached port");
    fr(INS_ADDR_WR, 2'h0, {24'h0, SEL_REV_ID});
    fr(INS_DATA_RD, 2'h1, 32'h0);
    chk(rd, {24'h0, REV}, "revision id not right-justified");
    fr(INS_DATA_WR, 2'h0, 32'h0000_0077);
    fr(INS_DATA_RD, 2'h0, 32'h0);
    chk(wr_cnt, n, "revision id write reached port");
    chk(rd, {24'h0, REV}, "revision id not read-only");
    $display("test ident done");
  endtask : t_ident

  task automatic t_status();
    wait_clk(1);
    eng_mem_busy = 1'b1;
    eng_mem_err = 1'b1;
    wait_clk(10);
    fr(INS_ADDR_RD, 2'h0, 32'h0);
    chk(rd, 32'h0000_00c0, "busy and error status");
    wait_clk(1);
    eng_mem_busy = 1'b0;
    eng_mem_err = 1'b0;
    eng_out_ready = 1'b1;
    wait_clk(10);
    fr(INS_ADDR_RD, 2'h0, 32'h0);
    chk(rd, 32'h0000_0001, "output available status");
    $display("test status done");
  endtask : t_status

  task automatic t_prog();
    int n;
    n = wr_cnt;
    fr(INS_ADDR_WR, 2'h0, {24'h0, PSEL});
    fr(INS_DATA_WR, 2'h1, 32'h0000_3412);
    chk(wr_cnt, n + 1, "port write count");
    chk({wr_addr, wr_data}, {PSEL, 8'h34}, "last byte written");
    fr(INS_ADDR_RD, 2'h0, 32'h0);
    // poll input pending after port write
    chk(rd, 32'h0000_0003, "input pending not set");
    wait_clk(1);
    eng_in_ack = 1'b1;
    wait_clk(1);
    eng_in_ack = 1'b0;
    wait_clk(10);
    fr(INS_ADDR_RD, 2'h0, 32'h0);
    chk(rd, 32'h0000_0001, "input pending not cleared");
    fr(INS_DATA_RD, 2'h2, 32'h0);
    chk(rd, {24'h0, PSEL ^ 8'ha5}, "port read zero padded");
    $display("test prog done");
  endtask : t_prog

  task automatic t_pinrst();
    fr(INS_ADDR_WR, 2'h0, 32'h0000_0005);
    i_m.tick(1'b0, 1'b0, b);
    i_m.tick(1'b1, 1'b1, b);
    fork
      i_m.pin_reset((RST_N + 15) * 50);
      begin
        #((RST_N + 8) * 50);
        chk(dev_reset, 1'b1, "long low not a reset");
      end
    join
    chk(dev_reset, 1'b0, "reset stuck");
    fr(INS_DATA_RD, 2'h0, 32'h0);
    chk(rd, {24'h0, PART}, "selector not cleared");
    fr(INS_ADDR_WR, 2'h0, 32'h0000_0005);
    fr(INS_DATA_RD, 2'h0, 32'h0);
    chk(rd, 32'h0000_00a0, "frames after abandoned frame");
    $display("test pinrst done");
  endtask : t_pinrst

  // watchdog
  initial
  begin
    #3000000;
    err_count++;
    results();
  end

  // reset with link strobes, then the scenarios
  initial
  begin
    fork
      repeat (4) @(posedge clk);
      repeat (4) i_m.tick(1'b0, 1'b0, b);
    join
    #1 sys_rst = 1'b0;
    // two edges carry the release to the link side; a third would open a frame
    repeat (2) i_m.tick(1'b0, 1'b0, b);
    wait_clk(10);
    t_ident();
    t_status();
    t_prog();
    t_pinrst();
    results();
  end
endmodule : twdt_target_tb
